// ---- cmsd_pkg.sv ----
// Shared encodings and constants for the control mode strap decoder.
`default_nettype none
package cmsd_pkg;
    // Three-level pin value as seen by the digital logic.
    typedef enum logic [1:0] {
        CMSD_LVL_LOW = 2'h0,
        CMSD_LVL_MID = 2'h1,
        CMSD_LVL_HIGH = 2'h3
    } cmsd_level_e;

    // Control interface chosen by the straps.
    typedef enum logic [1:0] {
        CMSD_IF_HW = 2'h0,
        CMSD_IF_SERIAL = 2'h1,
        CMSD_IF_PARALLEL = 2'h3
    } cmsd_iface_e;

    // Parallel host styles, coded as {bus_mux_select, host_style_select}.
    typedef enum logic [1:0] {
        CMSD_PAR_NM_MOTO = 2'h0,
        CMSD_PAR_NM_INTL = 2'h1,
        CMSD_PAR_MX_MOTO = 2'h2,
        CMSD_PAR_MX_INTL = 2'h3
    } cmsd_par_e;

    // Jitter attenuator placement.
    typedef enum logic [1:0] {
        CMSD_JA_TX = 2'h0,
        CMSD_JA_OFF = 2'h1,
        CMSD_JA_RX = 2'h3
    } cmsd_ja_e;

    localparam int CMSD_TS_W = 3;
    localparam int CMSD_LP_W = 8;
    localparam int CMSD_ADDR_W = 5;
    localparam int CMSD_AD_W = 8;
    localparam logic [3:0] CMSD_LATCH_CYCLES = 4'h2;
endpackage
`default_nettype wire

// ---- cmsd_if.sv ----
// Strap and host-port pins between the board/host end and the device end.
`default_nettype none
interface cmsd_if;
    import cmsd_pkg::*;
    logic [1:0] control_iface_select;
    logic bus_mux_select;
    logic host_style_select;
    logic [1:0] cs_jas_level;
    logic [CMSD_TS_W-1:0] template_select;
    logic [CMSD_LP_W-1:0] loopback_select;
    logic clock_edge_select;
    logic out_enable_pin;
    logic addr_latch_strobe;
    logic [CMSD_AD_W-1:0] ad_bus;

    modport device (
        input control_iface_select, bus_mux_select, host_style_select, cs_jas_level,
        input template_select, loopback_select, clock_edge_select, out_enable_pin,
        input addr_latch_strobe, ad_bus
    );
    modport board (
        output control_iface_select, bus_mux_select, host_style_select, cs_jas_level,
        output template_select, loopback_select, clock_edge_select, out_enable_pin,
        output addr_latch_strobe, ad_bus
    );
endinterface
`default_nettype wire

// ---- cmsd_device.sv ----
// Device end: latches straps and decodes control mode and global settings.
`default_nettype none
module cmsd_device
    import cmsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    cmsd_if.device pins,
    output logic straps_valid,
    output cmsd_iface_e iface_mode,
    output cmsd_par_e par_style,
    output logic par_muxed,
    output logic par_style_b,
    output logic line_code_ami,
    output cmsd_ja_e ja_place,
    output logic [CMSD_TS_W-1:0] hw_template,
    output logic [CMSD_LP_W-1:0] hw_loopback,
    output logic hw_clock_edge,
    output logic hw_out_enable,
    output logic host_port_enabled,
    output logic serial_port_active,
    output logic [CMSD_ADDR_W-1:0] latched_addr,
    output logic addr_valid
);
    logic [3:0] settle_r;
    logic [1:0] mode_lvl_r;
    logic mux_r;
    logic style_r;
    logic [1:0] jas_r;
    logic ale_prev_r;
    logic [CMSD_ADDR_W-1:0] addr_r;
    logic addr_valid_r;

    wire latch_now = (settle_r == CMSD_LATCH_CYCLES);
    wire is_hw = (mode_lvl_r == CMSD_LVL_LOW);
    wire is_ser = (mode_lvl_r == CMSD_LVL_MID);
    wire is_par = (mode_lvl_r == CMSD_LVL_HIGH);
    // In host modes the shared pin is the chip select; mid level reads as high.
    wire cs_n = (pins.cs_jas_level != CMSD_LVL_LOW);
    wire muxed_now = is_par && mux_r;
    wire strobe_fall = ale_prev_r && !pins.addr_latch_strobe;

    // Straps are captured a fixed time after reset, never under reset itself.
    always_ff @(posedge clk) begin
        if (rst) begin
            settle_r <= 4'h0;
        end else if (settle_r <= CMSD_LATCH_CYCLES) begin
            settle_r <= settle_r + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_lvl_r <= 2'h0;
            mux_r <= 1'b0;
            style_r <= 1'b0;
            jas_r <= 2'h0;
        end else if (latch_now) begin
            mode_lvl_r <= pins.control_iface_select;
            mux_r <= pins.bus_mux_select;
            style_r <= pins.host_style_select;
            jas_r <= pins.cs_jas_level;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ale_prev_r <= 1'b1;
            addr_r <= 5'h00;
            addr_valid_r <= 1'b0;
        end else begin
            ale_prev_r <= pins.addr_latch_strobe;
            // Both multiplexed styles latch on the falling strobe; top lines dropped.
            if (muxed_now && !cs_n && strobe_fall) begin
                addr_r <= pins.ad_bus[CMSD_ADDR_W-1:0];
                addr_valid_r <= 1'b1;
            end else if (cs_n) begin
                addr_valid_r <= 1'b0;
            end
        end
    end

    // Outputs become meaningful only once the straps have been latched.
    assign straps_valid = (settle_r > CMSD_LATCH_CYCLES);
    assign iface_mode = is_ser ? CMSD_IF_SERIAL : (is_par ? CMSD_IF_PARALLEL : CMSD_IF_HW);
    assign par_style = cmsd_par_e'({mux_r, style_r});
    assign par_muxed = muxed_now;
    assign par_style_b = is_par && style_r;
    // Host style and line code share a pin; only hardware mode reads it as line code.
    assign line_code_ami = is_hw && style_r;
    assign ja_place = !is_hw ? CMSD_JA_OFF
        : (jas_r == CMSD_LVL_LOW) ? CMSD_JA_TX
        : (jas_r == CMSD_LVL_HIGH) ? CMSD_JA_RX : CMSD_JA_OFF;
    // Template, loopback, edge and enable pins are live only in hardware mode.
    assign hw_template = is_hw ? pins.template_select : 3'h0;
    assign hw_loopback = is_hw ? pins.loopback_select : 8'h00;
    assign hw_clock_edge = is_hw && pins.clock_edge_select;
    assign hw_out_enable = is_hw && pins.out_enable_pin;
    assign host_port_enabled = !is_hw && straps_valid && !cs_n;
    assign serial_port_active = is_ser && straps_valid && !cs_n;
    assign latched_addr = addr_r;
    assign addr_valid = addr_valid_r;
endmodule
`default_nettype wire

// ---- cmsd_board.sv ----
// Board and host end: drives straps and the host chip select and strobe.
`default_nettype none
module cmsd_board
    import cmsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    cmsd_if.board pins,
    input wire cmsd_iface_e want_iface,
    input wire logic want_muxed,
    input wire logic want_style_b,
    input wire logic want_ami,
    input wire cmsd_ja_e want_ja,
    input wire logic [CMSD_TS_W-1:0] want_template,
    input wire logic [CMSD_LP_W-1:0] want_loopback,
    input wire logic want_edge,
    input wire logic want_oe,
    input wire logic access_req,
    input wire logic [CMSD_AD_W-1:0] access_addr,
    output logic access_busy
);
    typedef enum logic [1:0] {
        CMSD_B_IDLE = 2'h0,
        CMSD_B_SEL = 2'h1,
        CMSD_B_ADDR = 2'h3,
        CMSD_B_DONE = 2'h2
    } cmsd_bstate_e;

    cmsd_bstate_e st_r;
    cmsd_bstate_e st_nxt;
    logic [CMSD_AD_W-1:0] ad_r;

    wire host = (want_iface != CMSD_IF_HW);
    wire par = (want_iface == CMSD_IF_PARALLEL);
    wire cs_low = (st_r != CMSD_B_IDLE);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            CMSD_B_IDLE: begin
                if (access_req && host) begin
                    st_nxt = CMSD_B_SEL;
                end
            end
            CMSD_B_SEL: st_nxt = CMSD_B_ADDR;
            CMSD_B_ADDR: st_nxt = CMSD_B_DONE;
            default: st_nxt = CMSD_B_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= CMSD_B_IDLE;
            ad_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            if (st_r == CMSD_B_IDLE && access_req) begin
                ad_r <= access_addr;
            end
        end
    end

    assign pins.control_iface_select = want_iface;
    assign pins.bus_mux_select = par && want_muxed;
    // Shared pin: host style in parallel, line code in hardware, ground in serial.
    assign pins.host_style_select = par ? want_style_b
        : (want_iface == CMSD_IF_HW) ? want_ami : 1'b0;
    // Chip select returns high for one idle cycle between accesses.
    assign pins.cs_jas_level = host ? (cs_low ? CMSD_LVL_LOW : CMSD_LVL_HIGH)
        : want_ja;
    assign pins.template_select = want_template;
    assign pins.loopback_select = want_loopback;
    assign pins.clock_edge_select = want_edge;
    assign pins.out_enable_pin = want_oe;
    assign pins.addr_latch_strobe = !(par && want_muxed && st_r == CMSD_B_ADDR);
    assign pins.ad_bus = ad_r;
    assign access_busy = cs_low;
endmodule
`default_nettype wire

// ---- cmsd_asserts.sv ----
// Concurrent checks on the strap and host-port pins joining the two ends.
`default_nettype none
module cmsd_asserts
    import cmsd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] control_iface_select,
    input wire logic bus_mux_select,
    input wire logic host_style_select,
    input wire logic [1:0] cs_jas_level,
    input wire logic addr_latch_strobe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Chip select only means something in a host mode; in hardware mode the pin is placement.
    wire logic cs_low = (control_iface_select != 2'h0) && (cs_jas_level == 2'h0);
    wire logic muxed_par = bus_mux_select && (control_iface_select == 2'h3);
    sequence s_cs_fall;
        $rose(cs_low);
    endsequence
    sequence s_strobe_pulse;
        !addr_latch_strobe ##1 addr_latch_strobe;
    endsequence
    a_cs_low_span: assert property (s_cs_fall |-> cs_low[*3] ##1 !cs_low)
        else $error("chip select low span wrong");
    // One idle cycle between accesses is legal, so the check is on how long the low lasted.
    a_cs_fresh_fall: assert property ($fell(cs_low) |-> $past(cs_low, 3))
        else $error("chip select rose before the access ended");
    a_mux_grounded: assert property (control_iface_select != 2'h3 |-> !bus_mux_select)
        else $error("bus mux select high outside parallel mode");
    a_style_grounded: assert property (control_iface_select == 2'h1 |-> !host_style_select)
        else $error("host style select high in serial mode");
    a_strobe_nonmux: assert property (control_iface_select == 2'h3 && !bus_mux_select
        |-> addr_latch_strobe)
        else $error("address strobe low in non-multiplexed mode");
    a_strobe_in_cs: assert property ($fell(addr_latch_strobe) |-> cs_low)
        else $error("address strobe fell with chip select high");
    a_strobe_after_sel: assert property (s_cs_fall ##0 muxed_par |=> s_strobe_pulse)
        else $error("address strobe pulse missing after select");
    a_straps_static: assert property ($stable({control_iface_select, bus_mux_select}))
        else $error("mode straps changed while running");
    a_level_codes: assert property (control_iface_select != 2'h2 && cs_jas_level != 2'h2)
        else $error("three-level pin carries an unused code");
endmodule
`default_nettype wire

// ---- control_mode_strap_decoder_tb_top.sv ----
// Self-checking bench joining the board end and the device end of the strap decoder.
`default_nettype none
module control_mode_strap_decoder_tb_top
    import cmsd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, want_muxed = 0, want_style_b = 0, want_ami = 0, want_edge = 0;
    logic want_oe = 0, access_req = 0, straps_valid, par_muxed, par_style_b, line_code_ami;
    logic hw_clock_edge, hw_out_enable, host_port_enabled, serial_port_active, addr_valid;
    logic [CMSD_TS_W-1:0] want_template = 3'h0, hw_template;
    logic [CMSD_LP_W-1:0] want_loopback = 8'h00, hw_loopback;
    logic [CMSD_AD_W-1:0] access_addr = 8'h00;
    logic [CMSD_ADDR_W-1:0] latched_addr;
    cmsd_iface_e want_iface = CMSD_IF_HW, iface_mode;
    cmsd_ja_e want_ja = CMSD_JA_TX, ja_place;
    cmsd_par_e par_style;
    int mismatches = 0, compares = 0, cycles = 0;
    cmsd_if link();
    cmsd_board cmsd_board_inst(.clk, .rst, .pins(link), .want_iface, .want_muxed, .want_style_b,
        .want_ami, .want_ja, .want_template, .want_loopback, .want_edge, .want_oe,
        .access_req, .access_addr, .access_busy());
    cmsd_device cmsd_device_inst(.clk, .rst, .pins(link), .straps_valid, .iface_mode,
        .par_style, .par_muxed, .par_style_b, .line_code_ami, .ja_place, .hw_template,
        .hw_loopback, .hw_clock_edge, .hw_out_enable, .host_port_enabled,
        .serial_port_active, .latched_addr, .addr_valid);
    cmsd_asserts cmsd_asserts_inst(.clk, .rst, .control_iface_select(link.control_iface_select),
        .bus_mux_select(link.bus_mux_select), .host_style_select(link.host_style_select),
        .cs_jas_level(link.cs_jas_level), .addr_latch_strobe(link.addr_latch_strobe));
    always #5 clk = ~clk;
    // A hang must still end in the report, so the limit is well above the planned run.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk) #1;
    endtask
    // Straps are only taken at start-up, so every new setting goes through a reset.
    task automatic restart();
        rst = 1;
        step(2);
        rst = 0;
        step(6);
        chk("straps_valid", 8'h01, straps_valid);
    endtask
    task automatic t_modes();
        for (int i = 0; i < 6; i++) begin
            want_iface = (i == 0) ? CMSD_IF_HW : (i == 1) ? CMSD_IF_SERIAL : CMSD_IF_PARALLEL;
            want_muxed = (i >= 4);
            want_style_b = (i >= 2) && i[0];
            restart();
            chk("iface_mode", want_iface, iface_mode);
            if (i >= 2) begin
                chk("par_style", {want_muxed, want_style_b}, par_style);
                chk("par_muxed", want_muxed, par_muxed);
                chk("par_style_b", want_style_b, par_style_b);
            end
            chk("serial_port_active", 8'h00, serial_port_active);
        end
    endtask
    task automatic t_hw();
        want_iface = CMSD_IF_HW;
        {want_muxed, want_style_b, want_template, want_loopback} = {2'h0, 3'h5, 8'hA6};
        for (int j = 0; j < 3; j++) begin
            want_ja = (j == 0) ? CMSD_JA_TX : (j == 1) ? CMSD_JA_OFF : CMSD_JA_RX;
            want_ami = j[0];
            want_edge = j[1];
            want_oe = !j[0];
            restart();
            chk("ja_place", want_ja, ja_place);
            chk("line_code_ami", want_ami, line_code_ami);
            chk("hw_template", 8'h05, hw_template);
            chk("hw_loopback", 8'hA6, hw_loopback);
            chk("hw_clock_edge", want_edge, hw_clock_edge);
            chk("hw_out_enable", want_oe, hw_out_enable);
        end
    endtask
    task automatic t_access(input cmsd_iface_e f, input logic mx, input logic [7:0] a,
        input logic v);
        logic seen_v = 0, seen_en = 0, seen_ser = 0;
        logic [4:0] la = 5'h00;
        {want_iface, want_muxed, want_style_b, access_addr} = {f, mx, f == CMSD_IF_PARALLEL, a};
        restart();
        access_req = 1;
        step(1);
        access_req = 0;
        repeat (8) begin
            seen_en |= host_port_enabled;
            seen_ser |= serial_port_active;
            if (addr_valid === 1'b1) {seen_v, la} = {1'b1, latched_addr};
            step(1);
        end
        chk("host_port_enabled", 8'h01, seen_en);
        chk("serial_port_active", f == CMSD_IF_SERIAL, seen_ser);
        chk("addr_valid", v, seen_v);
        if (v) chk("latched_addr", a[4:0], la);
        chk("host_port_idle", 8'h00, host_port_enabled);
        // Hardware-only pins must read as zero once a host mode owns them.
        chk("hw_loopback_host", 8'h00, hw_loopback);
        chk("line_code_host", 8'h00, line_code_ami);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        step(20);
        t_modes();
        t_hw();
        t_access(CMSD_IF_PARALLEL, 1'b1, 8'hF5, 1'b1);
        t_access(CMSD_IF_PARALLEL, 1'b0, 8'h0A, 1'b0);
        t_access(CMSD_IF_SERIAL, 1'b0, 8'h13, 1'b0);
        final_report();
    end
endmodule
`default_nettype wire
